// File: dv/channel_pulse_processor_assertions.sv
/*
  Checker for the link between channel and readout end: settings burst,
  event hold and release, direct waveform stream.
  Assumes one clock mclk and a synchronous active-high rst; instantiated beside the link.
*/
`timescale 1ns/1ps
module channel_pulse_processor_assertions #(
  parameter int TRACE_WORDS = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cfg_we,
  input wire logic [3:0] cfg_addr,
  input wire logic event_ready,
  input wire logic rd_en,
  input wire logic [3:0] rd_addr,
  input wire logic wave_en,
  input wire logic wave_valid,
  input wire logic wave_last
);
  import pulse_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  int wave_cnt;
  ////////////////////////////////////////////////////////////////////////////////
  // Words seen in the current waveform, cleared by its last word
  always_ff @(posedge mclk) begin
    if (rst || wave_last) begin
      wave_cnt <= 0;
    end else if (wave_valid) begin
      wave_cnt <= wave_cnt + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence cfg_burst;
    cfg_we [*8] ##1 !cfg_we;
  endsequence
  sequence done_read;
    rd_en && rd_addr == RD_DONE;
  endsequence
  a_cfg_burst_whole: assert property ($rose(cfg_we) |-> cfg_addr == 4'h0 ##0 cfg_burst)
    else $error("settings burst not eight words from word zero");
  a_cfg_addr_step: assert property (cfg_we && $past(cfg_we) |-> cfg_addr == $past(cfg_addr) + 4'h1)
    else $error("settings address did not step by one");
  a_ready_held: assert property (event_ready && !(rd_en && rd_addr == RD_DONE) |=> event_ready)
    else $error("event released before done read");
  a_done_clears: assert property (event_ready and done_read |=> !event_ready)
    else $error("event still held after done read");
  a_read_held_event: assert property (rd_en |-> event_ready)
    else $error("event read with no event held");
  a_ready_served: assert property ($rose(event_ready) |-> ##[1:400] !event_ready)
    else $error("held event not read out in time");
  a_wave_enabled: assert property (wave_valid |-> event_ready && (wave_en || $past(wave_en)))
    else $error("waveform word without held event and enable");
  a_wave_burst: assert property ($rose(wave_valid) |-> wave_valid [*8])
    else $error("waveform stream broke up");
  a_last_count: assert property (wave_last |-> wave_valid && wave_cnt == TRACE_WORDS - 1)
    else $error("waveform length differs from trace length");
  a_last_stops: assert property (wave_last |=> !wave_valid)
    else $error("waveform word after last word");
endmodule : channel_pulse_processor_assertions

// File: dv/channel_pulse_processor_bench.sv
/*
  Testbench: channel processor and readout end joined by their link, readout
  commanded over AHB-Lite. Assumes mclk at 10 MHz and a 4-cycle reset.
*/
`timescale 1ns/1ps
module channel_pulse_processor_bench;
  import pulse_pkg::*;
  localparam int TRACE_WORDS = 16;
  localparam logic [31:0] SET [8] = '{32'h0000_0001, 32'h0000_03e8, 32'h0000_0004,
    32'h0000_0002, 32'h0000_0000, 32'h0000_0010, 32'h0000_0001, 32'h0000_0001};
  logic mclk, rst, hsel, hwrite, hreadyout, hresp, module_veto, fifo_valid, force_trig, trig_out;
  logic [31:0] haddr, hwdata, hrdata, fifo_data;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [WIDE_W-1:0] adc_word;
  logic flag_pend = 1'b0;
  logic [31:0] flags_log [16];
  int err_count = 0, comparisons = 0, wave_words = 0, trig_seen = 0, done_cnt = 0;
  chan_link_if link();
  channel_pulse_processor channel_pulse_processor_inst (.mclk(mclk), .rst(rst),
    .adc_word(adc_word), .force_trig(force_trig), .link(link.channel), .trig_out(trig_out));
  event_reader event_reader_inst (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .module_veto(module_veto),
    .link(link.reader), .fifo_data(fifo_data), .fifo_valid(fifo_valid));
  channel_pulse_processor_assertions #(.TRACE_WORDS(TRACE_WORDS))
    channel_pulse_processor_assertions_inst (.mclk(mclk), .rst(rst), .cfg_we(link.cfg_we),
    .cfg_addr(link.cfg_addr), .event_ready(link.event_ready), .rd_en(link.rd_en),
    .rd_addr(link.rd_addr), .wave_en(link.wave_en), .wave_valid(link.wave_valid),
    .wave_last(link.wave_last));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Monitor: flags are logged straight off the link, not from the reader's copy
  always @(posedge mclk) begin
    if (fifo_valid === 1'b1) wave_words <= wave_words + 1;
    if (trig_out === 1'b1) trig_seen <= trig_seen + 1;
    if (link.rd_en === 1'b1 && link.rd_addr === RD_DONE) done_cnt <= done_cnt + 1;
    flag_pend <= (link.rd_en === 1'b1 && link.rd_addr === RD_FLAGS);
    if (flag_pend) flags_log[done_cnt[3:0]] <= link.rd_data;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task complete_run;
    $display("counts: %0d mismatches in %0d comparisons", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task automatic give_up(input string what);
    err_count++;
    $display("mismatch at %0t: %s timed out", $time, what);
    complete_run;
  endtask : give_up
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    @(posedge mclk);
    while (hreadyout !== 1'b1 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge mclk);
    while (hreadyout !== 1'b1 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    q = hrdata;
    if (n >= 50) give_up("bus answer");
  endtask : ahb
  task automatic wait_done(input int target);
    int n;
    n = 0;
    while (done_cnt < target && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 3000) give_up("event readout");
  endtask : wait_done
  task automatic pulse_force;
    force_trig <= 1'b1;
    @(posedge mclk);
    force_trig <= 1'b0;
    @(posedge mclk);
  endtask : pulse_force
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_map;
    logic [31:0] q;
    ahb(1'b0, 32'h0000_0080, 32'h0, q);
    check(q, 32'h0000_0000, "unmapped word");
    check({31'h0, hresp}, 32'h0, "bus response");
    ahb(1'b0, 32'h0000_0044, 32'h0, q);
    check(q, 32'h0000_0000, "recorded after reset");
    check({31'h0, link.event_ready}, 32'h0, "event held after reset");
  endtask : t_map
  task automatic t_load;
    logic [31:0] q;
    int i;
    for (i = 0; i < 8; i++) ahb(1'b1, 32'(i * 4), SET[i], q);
    ahb(1'b1, 32'h0000_0020, CTL_START, q);
    q = 32'h1;
    for (i = 0; i < 40 && q[0] !== 1'b0; i++) ahb(1'b0, 32'h0000_0020, 32'h0, q);
    check({31'h0, q[0]}, 32'h0, "load finished");
    for (i = 0; i < 8; i++) begin
      ahb(1'b0, 32'(i * 4), 32'h0, q);
      check(q, SET[i], "setting readback");
    end
    check(32'(trig_seen), 32'h0, "trigger on flat baseline");
  endtask : t_load
  task automatic t_forced;
    logic [31:0] q;
    pulse_force();
    wait_done(1);
    check({29'h0, flags_log[0][6:4]}, {29'h0, FORCED_SOURCE}, "forced source");
    check({31'h0, flags_log[0][FL_PILEUP]}, 32'h0, "lone pulse pileup");
    check({31'h0, flags_log[0][FL_VALID]}, 32'h1, "lone pulse valid");
    check(32'(wave_words), 32'(TRACE_WORDS), "waveform words");
    check(32'(trig_seen), 32'h1, "trigger pulses");
    ahb(1'b0, 32'h0000_0038, 32'h0, q);
    check(q, flags_log[0], "flags mirrored to bus");
    ahb(1'b0, 32'h0000_0040, 32'h0, q);
    check(q, 32'h0000_0001, "trigger count");
    ahb(1'b0, 32'h0000_003c, 32'h0, q);
    check({31'h0, q != 32'h0}, 32'h1, "run time advancing");
    ahb(1'b0, 32'h0000_0044, 32'h0, q);
    check(q, 32'h0000_0001, "recorded count");
  endtask : t_forced
  task automatic t_pileup;
    logic [31:0] q;
    int i;
    pulse_force();
    pulse_force();
    wait_done(3);
    for (i = 1; i < 3; i++) begin
      check({31'h0, flags_log[i][FL_PILEUP]}, 32'h1, "close pair pileup");
      check({31'h0, flags_log[i][FL_VALID]}, 32'h0, "piled event rejected");
    end
    check(32'(wave_words), 32'(TRACE_WORDS), "no waveform for rejected");
    ahb(1'b0, 32'h0000_0040, 32'h0, q);
    check(q, 32'h0000_0003, "trigger count");
  endtask : t_pileup
  task automatic t_veto;
    logic [31:0] q;
    module_veto <= 1'b1;
    pulse_force();
    wait_done(4);
    module_veto <= 1'b0;
    check({31'h0, flags_log[3][FL_VETO]}, 32'h1, "veto flag");
    check({31'h0, flags_log[3][FL_VALID]}, 32'h0, "vetoed event valid");
    ahb(1'b0, 32'h0000_0044, 32'h0, q);
    check(q, 32'h0000_0001, "vetoed not recorded");
  endtask : t_veto
  task automatic t_edge;
    logic [31:0] q;
    // A step on all five packed samples must trip the fast filter by itself
    adc_word <= {5{14'h0bb8}};
    wait_done(5);
    check(32'(trig_seen), 32'h5, "edge trigger");
    check({31'h0, flags_log[4][6:4] < 3'h5}, 32'h1, "edge source position");
    check({31'h0, flags_log[4][FL_VALID]}, 32'h1, "edge event valid");
    check(32'(wave_words), 32'(2 * TRACE_WORDS), "edge waveform words");
    ahb(1'b0, 32'h0000_0044, 32'h0, q);
    check(q, 32'h0000_0002, "recorded count");
  endtask : t_edge
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    module_veto = 1'b0;
    force_trig = 1'b0;
    adc_word = {5{14'h0064}};
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_map();
    t_load();
    t_forced();
    t_pileup();
    t_veto();
    t_edge();
    complete_run();
  end
endmodule : channel_pulse_processor_bench

// File: rtl/chan_link_if.sv
/*
  Link between the channel processor and its readout end: settings writes,
  event reads, validation return and direct waveform transfer.
  Assumes both ends share mclk.
*/
`timescale 1ns/1ps
interface chan_link_if;
  logic cfg_we;
  logic [3:0] cfg_addr;
  logic [31:0] cfg_data;
  logic event_ready;
  logic rd_en;
  logic [3:0] rd_addr;
  logic [31:0] rd_data;
  logic validate;
  logic veto;
  logic wave_en;
  logic wave_valid;
  logic [31:0] wave_data;
  logic wave_last;
  modport channel (input cfg_we, cfg_addr, cfg_data, rd_en, rd_addr, validate, veto,
    wave_en, output event_ready, rd_data, wave_valid, wave_data, wave_last);
  modport reader (output cfg_we, cfg_addr, cfg_data, rd_en, rd_addr, validate, veto,
    wave_en, input event_ready, rd_data, wave_valid, wave_data, wave_last);
endinterface : chan_link_if

// File: rtl/channel_pulse_processor.sv
/*
  Channel pulse processor: packed sample intake, fast and slow trapezoidal
  filters, trigger, pileup, delay and storage memories, event hold, counters.
  Assumes samples arrive packed, five per mclk, synchronous to mclk.
*/
// The implementer's own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module channel_pulse_processor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [pulse_pkg::WIDE_W-1:0] adc_word,
  input wire logic force_trig,
  chan_link_if.channel link,
  output logic trig_out
);
  import pulse_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_WAIT = 4'b0010,
    S_CAPT = 4'b0100,
    S_HOLD = 4'b1000
  } state_type;
  state_type state;
  logic [9:0] fast_len;
  logic [FILT_W-1:0] fast_thr;
  logic [9:0] slow_len;
  logic [9:0] slow_gap;
  logic [DELAY_AW-1:0] pre_trig;
  logic [STORE_AW-1:0] trace_len;
  logic accept_no_pileup;
  logic run_en;
  // Settings stored on each settings-bus write; held until the reader loads them again
  always_ff @(posedge mclk) begin
    if (rst) begin
      fast_len <= 10'h001;
      fast_thr <= '0;
      slow_len <= 10'h004;
      slow_gap <= 10'h002;
      pre_trig <= '0;
      trace_len <= 12'h010;
      accept_no_pileup <= 1'b0;
      run_en <= 1'b0;
    end else if (link.cfg_we) begin
      case (link.cfg_addr)
        CFG_FAST_LEN: fast_len <= link.cfg_data[9:0];
        CFG_FAST_THR: fast_thr <= link.cfg_data[FILT_W-1:0];
        CFG_SLOW_LEN: slow_len <= link.cfg_data[9:0];
        CFG_SLOW_GAP: slow_gap <= link.cfg_data[9:0];
        CFG_PRE_TRIG: pre_trig <= link.cfg_data[DELAY_AW-1:0];
        CFG_TRACE_LEN: trace_len <= link.cfg_data[STORE_AW-1:0];
        CFG_ACCEPT: accept_no_pileup <= link.cfg_data[0];
        CFG_RUN: run_en <= link.cfg_data[0];
        default: ;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Five samples per cycle are summed into one wide-word value; trade-off:
  // the filters resolve time to one processing cycle, source field gives
  // the position inside the word.
  logic [SAMPLE_W+2:0] word_sum;
  logic [SAMPLE_W+2:0] hist [0:DELAY_DEPTH-1];
  logic [DELAY_AW-1:0] wp;
  logic [FILT_W-1:0] fast_val;
  logic [FILT_W-1:0] slow_lead;
  logic [FILT_W-1:0] slow_gsum;
  logic [FILT_W-1:0] slow_trail;
  logic [FILT_W-1:0] fast_prev;
  logic [2:0] src_pos;
  logic [TS_W-1:0] ts;
  logic hist_full;
  always_comb begin
    word_sum = '0;
    for (int i = 0; i < PACK_N; i++) begin
      word_sum = word_sum + (SAMPLE_W+3)'(adc_word[i*SAMPLE_W +: SAMPLE_W]);
    end
  end
  // Slots not yet written read as zero, so the running sums never pick up unknowns
  function automatic logic [SAMPLE_W+2:0] tap(input logic [DELAY_AW-1:0] p,
                                               input logic [DELAY_AW-1:0] d);
    tap = (hist_full || DELAY_AW'(p - d) < p) ? hist[p - d] : '0;
  endfunction : tap
  // Running-sum trapezoids; both updated every cycle.
  always_ff @(posedge mclk) begin
    if (rst) begin
      wp <= '0;
      hist_full <= 1'b0;
      fast_val <= '0;
      fast_prev <= '0;
      slow_lead <= '0;
      slow_gsum <= '0;
      slow_trail <= '0;
    end else begin
      hist[wp] <= word_sum;
      wp <= wp + 1'b1;
      if (wp == '1) hist_full <= 1'b1;
      fast_prev <= fast_val;
      fast_val <= fast_val + FILT_W'(word_sum) - FILT_W'(tap(wp, fast_len[DELAY_AW-1:0]));
      slow_lead <= slow_lead + FILT_W'(word_sum) - FILT_W'(tap(wp, slow_len[DELAY_AW-1:0]));
      slow_gsum <= slow_gsum + FILT_W'(tap(wp, slow_len[DELAY_AW-1:0]))
        - FILT_W'(tap(wp, DELAY_AW'(slow_len + slow_gap)));
      slow_trail <= slow_trail + FILT_W'(tap(wp, DELAY_AW'(slow_len + slow_gap)))
        - FILT_W'(tap(wp, DELAY_AW'(2 * slow_len + slow_gap)));
    end
  end
  // First sample of the word above threshold gives source position
  always_comb begin
    src_pos = 3'h0;
    for (int i = PACK_N - 1; i >= 0; i--) begin
      if (adc_word[i*SAMPLE_W +: SAMPLE_W] > SAMPLE_W'(fast_thr >> 4)) src_pos = 3'(i);
    end
  end
  logic pend_trig;
  logic [TS_W-1:0] pend_ts;
  logic [2:0] pend_src;
  logic fast_edge;
  assign fast_edge = run_en && ((fast_val > fast_thr && fast_prev <= fast_thr) || force_trig);
  ////////////////////////////////////////////////////////////////////////////
  logic [TS_W-1:0] ev_ts;
  logic [2:0] ev_src;
  logic [FILT_W-1:0] ev_lead;
  logic [FILT_W-1:0] ev_gap;
  logic [FILT_W-1:0] ev_trail;
  logic ev_pileup;
  logic ev_veto;
  logic ev_valid;
  logic [10:0] wait_cnt;
  logic [STORE_AW-1:0] cap_cnt;
  logic [STORE_AW-1:0] out_cnt;
  logic [31:0] store [0:STORE_DEPTH-1];
  logic [CNT_W-1:0] run_time;
  logic [CNT_W-1:0] trig_cnt;
  logic read_done;
  assign read_done = link.rd_en && link.rd_addr == RD_DONE;
  // Event sequence: trigger, energy latch, capture, hold for readout
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= S_IDLE;
      pend_trig <= 1'b0;
      ev_ts <= '0;
      ev_src <= '0;
      ev_lead <= '0;
      ev_gap <= '0;
      ev_trail <= '0;
      ev_pileup <= 1'b0;
      ev_veto <= 1'b0;
      wait_cnt <= '0;
      cap_cnt <= '0;
      trig_out <= 1'b0;
    end else begin
      trig_out <= fast_edge;
      case (state)
        S_IDLE: begin
          if (pend_trig || fast_edge) begin
            ev_ts <= pend_trig ? pend_ts : ts;
            ev_src <= pend_trig ? pend_src : force_trig ? FORCED_SOURCE : src_pos;
            ev_pileup <= pend_trig;
            pend_trig <= 1'b0;
            ev_veto <= 1'b0;
            wait_cnt <= 11'(slow_len + slow_gap);
            cap_cnt <= '0;
            state <= S_WAIT;
          end
        end
        S_WAIT: begin
          // A trigger inside the filter length corrupts this sum; a pulse
          // on its own rising edge is not seen by the edge detector.
          if (fast_edge) begin
            ev_pileup <= 1'b1;
            pend_trig <= 1'b1;
            pend_ts <= ts;
            pend_src <= force_trig ? FORCED_SOURCE : src_pos;
          end
          if (wait_cnt == '0) begin
            ev_lead <= slow_lead;
            ev_gap <= slow_gsum;
            ev_trail <= slow_trail;
            state <= S_CAPT;
          end else begin
            wait_cnt <= wait_cnt - 1'b1;
          end
        end
        S_CAPT: begin
          if (link.veto || !link.validate) ev_veto <= 1'b1;
          if (cap_cnt == trace_len - 1'b1) state <= S_HOLD;
          cap_cnt <= cap_cnt + 1'b1;
        end
        S_HOLD: begin
          if (link.veto || !link.validate) ev_veto <= 1'b1;
          if (read_done) state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
  // Trace taken from pre-trigger delayed samples
  always_ff @(posedge mclk) begin
    if (state == S_CAPT || (state == S_WAIT)) begin
      store[cap_cnt] <= {15'h0000, tap(wp, pre_trig)};
    end
  end
  // Pileup rejection setting and module validation decide validity
  assign ev_valid = !(accept_no_pileup && ev_pileup) && !ev_veto;
  // Run statistics
  always_ff @(posedge mclk) begin
    if (rst) begin
      ts <= '0;
      run_time <= '0;
      trig_cnt <= '0;
    end else begin
      ts <= ts + 1'b1;
      if (run_en) run_time <= run_time + 1'b1;
      if (fast_edge) trig_cnt <= trig_cnt + 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Readout: event words, then direct waveform stream
  always_ff @(posedge mclk) begin
    if (rst) begin
      link.event_ready <= 1'b0;
      link.rd_data <= '0;
      link.wave_valid <= 1'b0;
      link.wave_data <= '0;
      link.wave_last <= 1'b0;
      out_cnt <= '0;
    end else begin
      link.event_ready <= state == S_HOLD && !read_done;
      if (link.rd_en) begin
        case (link.rd_addr)
          RD_TS_LO: link.rd_data <= ev_ts[31:0];
          RD_TS_HI: link.rd_data <= {16'h0000, ev_ts[TS_W-1:32]};
          RD_SUM_LEAD: link.rd_data <= 32'(ev_lead);
          RD_SUM_GAP: link.rd_data <= 32'(ev_gap);
          RD_SUM_TRAIL: link.rd_data <= 32'(ev_trail);
          RD_FLAGS: link.rd_data <= {25'h000_0000, ev_src, 1'b0, ev_veto, ev_valid, ev_pileup};
          RD_RUN_TIME: link.rd_data <= run_time;
          RD_TRIG_CNT: link.rd_data <= trig_cnt;
          default: link.rd_data <= RESET_WORD;
        endcase
      end
      link.wave_valid <= 1'b0;
      link.wave_last <= 1'b0;
      if (state != S_HOLD) begin
        out_cnt <= '0;
      end else if (link.wave_en && out_cnt != trace_len) begin
        link.wave_valid <= 1'b1;
        link.wave_data <= store[out_cnt];
        link.wave_last <= out_cnt == trace_len - 1'b1;
        out_cnt <= out_cnt + 1'b1;
      end
    end
  end
endmodule : channel_pulse_processor

// File: rtl/event_reader.sv
/*
  Readout end: loads settings, reads each held event, enables direct waveform
  transfer for recorded events, returns module validation. Commanded over AHB-Lite.
  Assumes shared mclk with the channel.
*/
`timescale 1ns/1ps
module event_reader (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic module_veto,
  chan_link_if.reader link,
  output logic [31:0] fifo_data,
  output logic fifo_valid
);
  import pulse_pkg::*;

  typedef enum logic [4:0] {
    R_IDLE = 5'b00001,
    R_READ = 5'b00010,
    R_WAVE = 5'b00100,
    R_DONE = 5'b01000,
    R_GAP = 5'b10000
  } rstate_type;

  rstate_type rstate;
  logic wr_pend;
  logic [5:0] wr_addr;
  logic [31:0] reg_cfg [0:7];
  logic [3:0] cfg_idx;
  logic cfg_busy;
  logic [3:0] rd_idx;
  logic [31:0] words [0:7];
  logic [CNT_W-1:0] recorded;

  ////////////////////////////////////////////////////////////////////////////
  // Word 0..7: settings; 8: control (write 1 loads all); 9..16: last event; 17: recorded
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= hsel && hready && htrans[1] && hwrite;
      if (hsel && hready && htrans[1]) begin
        wr_addr <= haddr[7:2];
        if (!hwrite) begin
          if (haddr[7:2] < 6'd8) hrdata <= reg_cfg[haddr[4:2]];
          else if (haddr[7:2] == 6'd8) hrdata <= {31'h0000_0000, cfg_busy};
          else if (haddr[7:2] < 6'd17) hrdata <= words[3'(haddr[7:2] - 6'd9)];
          else if (haddr[7:2] == 6'd17) hrdata <= recorded;
          else hrdata <= '0;
        end
      end
    end
  end

  logic start_load;
  assign start_load = wr_pend && wr_addr == 6'd8 && (hwdata & CTL_START) != '0;

  always_ff @(posedge mclk) begin
    if (wr_pend && wr_addr < 6'd8) reg_cfg[wr_addr[2:0]] <= hwdata;
  end

  // Settings pushed one per cycle into the channel
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_busy <= 1'b0;
      cfg_idx <= '0;
      link.cfg_we <= 1'b0;
      link.cfg_addr <= '0;
      link.cfg_data <= '0;
    end else begin
      link.cfg_we <= cfg_busy;
      link.cfg_addr <= cfg_idx;
      link.cfg_data <= reg_cfg[cfg_idx[2:0]];
      if (start_load) begin
        cfg_busy <= 1'b1;
        cfg_idx <= '0;
      end else if (cfg_busy) begin
        if (cfg_idx == CFG_RUN) cfg_busy <= 1'b0;
        cfg_idx <= cfg_idx + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Validation returned to the channel every cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      link.veto <= 1'b0;
      link.validate <= 1'b0;
    end else begin
      link.veto <= module_veto;
      link.validate <= !module_veto;
    end
  end

  // Read event words, decide from flags, stream trace if recorded
  always_ff @(posedge mclk) begin
    if (rst) begin
      rstate <= R_IDLE;
      rd_idx <= '0;
      recorded <= '0;
      link.rd_en <= 1'b0;
      link.rd_addr <= '0;
      link.wave_en <= 1'b0;
      fifo_valid <= 1'b0;
      fifo_data <= '0;
    end else begin
      link.rd_en <= 1'b0;
      fifo_valid <= link.wave_valid;
      fifo_data <= link.wave_data;
      case (rstate)
        R_IDLE: begin
          if (link.event_ready) begin
            rd_idx <= '0;
            link.rd_en <= 1'b1;
            link.rd_addr <= RD_TS_LO;
            rstate <= R_READ;
          end
        end
        R_READ: begin
          // Read data stands one cycle after its strobe, so capture lags the index by one
          if (rd_idx != 4'h0) words[3'(rd_idx - 1'b1)] <= link.rd_data;
          if (rd_idx > RD_TRIG_CNT) begin
            if (words[RD_FLAGS[2:0]][FL_VALID]) begin
              link.wave_en <= 1'b1;
              recorded <= recorded + 1'b1;
              rstate <= R_WAVE;
            end else begin
              rstate <= R_DONE;
            end
          end else begin
            rd_idx <= rd_idx + 1'b1;
            if (rd_idx != RD_TRIG_CNT) begin
              link.rd_en <= 1'b1;
              link.rd_addr <= rd_idx + 1'b1;
            end
          end
        end
        R_WAVE: begin
          if (link.wave_last) begin
            link.wave_en <= 1'b0;
            rstate <= R_DONE;
          end
        end
        R_DONE: begin
          link.rd_en <= 1'b1;
          link.rd_addr <= RD_DONE;
          rstate <= R_GAP;
        end
        R_GAP: rstate <= R_IDLE; // event_ready drops a cycle after done
        default: rstate <= R_IDLE;
      endcase
    end
  end
endmodule : event_reader

// File: rtl/pulse_pkg.sv
/*
  Shared constants for the channel pulse processor and its readout end.
  Assumes one processing clock (mclk) shared by both ends, synchronous active-high reset.
*/
package pulse_pkg;
  localparam int SAMPLE_W = 14;
  localparam int PACK_N = 5;
  localparam int WIDE_W = 70;
  localparam int FILT_W = 24;
  localparam int TS_W = 48;
  localparam int DELAY_DEPTH = 1024;
  localparam int DELAY_AW = 10;
  localparam int STORE_DEPTH = 4096;
  localparam int STORE_AW = 12;
  localparam int CNT_W = 32;
  localparam logic [2:0] FORCED_SOURCE = 3'h7;
  // Settings bus word addresses
  localparam logic [3:0] CFG_FAST_LEN = 4'h0;
  localparam logic [3:0] CFG_FAST_THR = 4'h1;
  localparam logic [3:0] CFG_SLOW_LEN = 4'h2;
  localparam logic [3:0] CFG_SLOW_GAP = 4'h3;
  localparam logic [3:0] CFG_PRE_TRIG = 4'h4;
  localparam logic [3:0] CFG_TRACE_LEN = 4'h5;
  localparam logic [3:0] CFG_ACCEPT = 4'h6;
  localparam logic [3:0] CFG_RUN = 4'h7;
  // Event read word addresses
  localparam logic [3:0] RD_TS_LO = 4'h0;
  localparam logic [3:0] RD_TS_HI = 4'h1;
  localparam logic [3:0] RD_SUM_LEAD = 4'h2;
  localparam logic [3:0] RD_SUM_GAP = 4'h3;
  localparam logic [3:0] RD_SUM_TRAIL = 4'h4;
  localparam logic [3:0] RD_FLAGS = 4'h5;
  localparam logic [3:0] RD_RUN_TIME = 4'h6;
  localparam logic [3:0] RD_TRIG_CNT = 4'h7;
  localparam logic [3:0] RD_DONE = 4'h8;
  // Flag word bit positions
  localparam int FL_PILEUP = 0;
  localparam int FL_VALID = 1;
  localparam int FL_VETO = 2;
  localparam int FL_SRC_LSB = 4;
  localparam logic [31:0] CTL_START = 32'h0000_0001;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage : pulse_pkg
